// file: rtl/ebp_defs.svh
/*
 Register offsets, field positions, reset values and timing counts
 for the enhanced bridge pwm block.
 Assumes inclusion by bare name from the block's rtl files.
*/
`ifndef EBP_DEFS_SVH
`define EBP_DEFS_SVH

// register byte offsets
`define EBP_ADDR_CTRL     8'h00
`define EBP_ADDR_DUTY_HI  8'h04
`define EBP_ADDR_DUTY_LAT 8'h08
`define EBP_ADDR_PERIOD   8'h0C
`define EBP_ADDR_TIMER    8'h10
`define EBP_ADDR_TCTRL    8'h14
`define EBP_ADDR_DEADBAND 8'h18
`define EBP_ADDR_PINDIR   8'h1C
`define EBP_ADDR_FLAG     8'h20
`define EBP_ADDR_STEER    8'h24

// enhanced_module_control fields
`define EBP_CFG_HI  7
`define EBP_CFG_LO  6
`define EBP_DLO_HI  5
`define EBP_DLO_LO  4
`define EBP_SEL_HI  3
`define EBP_SEL_LO  2
`define EBP_POL_AC  1
`define EBP_POL_BD  0
`define EBP_PWM_SEL 2'h3

// timer_control fields
`define EBP_TRUN 2
`define EBP_PS_HI 1
`define EBP_PS_LO 0

// reset values
`define EBP_RST_CTRL     8'h00
`define EBP_RST_DUTY_HI  8'h00
`define EBP_RST_PERIOD   8'hFF
`define EBP_RST_TCTRL    3'h0
`define EBP_RST_DEADBAND 7'h00
`define EBP_RST_PINDIR   4'hF
`define EBP_RST_STEER    4'h1

// timing counts
`define EBP_TCY_LAST   2'h3
`define EBP_DIR_LEAD   8'h04
`define EBP_PRE_MAX_1  4'h0
`define EBP_PRE_MAX_4  4'h3
`define EBP_PRE_MAX_16 4'hF

`endif

// file: rtl/ebp_pkg.sv
/*
 Types shared by the enhanced bridge pwm block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package ebp_pkg;
   // encoding order matches the 2-bit output configuration field
   typedef enum logic [1:0] {
      BM_SINGLE,
      BM_FULL_FWD,
      BM_HALF,
      BM_FULL_REV
   } ebp_bridge_mode_t;

   typedef enum logic [1:0] {
      GS_IDLE,
      GS_WAIT,
      GS_RUN
   } ebp_gen_state_t;

   typedef struct packed {
      logic [7:0] timer;
      logic [1:0] sub;
      logic period_start;
      logic inst_tick;
   } ebp_tb_t;
endpackage
`default_nettype wire

// file: rtl/ebp_timebase.sv
/*
 Period timer with prescaler and 2-bit sub-count forming the 10-bit
 time base, plus a free instruction-cycle tick of four clocks.
 Assumes one clock, async active-low reset.
*/
`include "ebp_defs.svh"
`default_nettype none
module ebp_timebase import ebp_pkg::*; (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_arst_n,
   // control
   input wire logic i_run,
   input wire logic [1:0] i_prescale_sel,
   input wire logic [7:0] i_period_limit,
   // time base
   output ebp_tb_t o_tb
);
   logic [1:0] tcy;
   logic [3:0] pc;
   logic [3:0] pre_max;
   logic step_sub;
   logic [7:0] timer;
   logic [1:0] sub;
   logic period_start;
   logic inst_tick;

   // one writer per field: each concern keeps its own flops, gathered here
   assign o_tb = '{timer: timer, sub: sub, period_start: period_start,
                   inst_tick: inst_tick};

   always_comb begin
      unique case (i_prescale_sel)
         2'h0: pre_max = `EBP_PRE_MAX_1;
         2'h1: pre_max = `EBP_PRE_MAX_4;
         default: pre_max = `EBP_PRE_MAX_16;
      endcase
   end

   assign step_sub = i_run && (pc >= pre_max);

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tcy <= 2'h0;
         inst_tick <= 1'b0;
      end else begin
         tcy <= tcy + 2'h1;
         inst_tick <= (tcy == `EBP_TCY_LAST);
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pc <= 4'h0;
         sub <= 2'h0;
         timer <= 8'h00;
         period_start <= 1'b0;
      end else begin
         period_start <= 1'b0;
         if (i_run) begin
            pc <= step_sub ? 4'h0 : pc + 4'h1;
         end
         if (step_sub) begin
            sub <= sub + 2'h1;
            if (sub == 2'h3) begin
               if (timer == i_period_limit) begin
                  timer <= 8'h00;
                  period_start <= 1'b1;
               end else begin
                  timer <= timer + 8'h01;
               end
            end
         end
      end
   end

   wrap_zero_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      o_tb.period_start |-> (o_tb.timer == 8'h00 && o_tb.sub == 2'h0))
      else $error("period start without cleared timer");
endmodule
`default_nettype wire

// file: rtl/ebp_deadband.sv
/*
 Delays one output's inactive-to-active edge by a count of
 instruction ticks; falling edges pass after one clock.
 Assumes i_tick is a one-clock pulse every instruction cycle.
*/
`default_nettype none
module ebp_deadband #(
   parameter int CW = 7
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_arst_n,
   // request
   input wire logic i_want,
   input wire logic i_tick,
   input wire logic [CW-1:0] i_count,
   // delayed output
   output logic o_active
);
   logic [CW-1:0] cnt;

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt <= '0;
         o_active <= 1'b0;
      end else if (!i_want) begin
         cnt <= '0;
         o_active <= 1'b0;
      end else if (cnt >= i_count) begin
         o_active <= 1'b1;
      end else if (i_tick) begin
         cnt <= cnt + CW'(1);
      end
   end

   drop_fast_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      !i_want |=> !o_active)
      else $error("output active without request");

   delay_met_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      $rose(o_active) |-> $past(cnt) >= $past(i_count))
      else $error("active edge before dead band elapsed");
endmodule
`default_nettype wire

// file: rtl/ebp_bridge_pwm.sv
/*
 Enhanced pwm output stage: duty buffer, base pwm, bridge steering,
 dead band, full-bridge direction change, polarity and registers.
 Assumes a plain register port with reads answered one cycle later,
 and port logic outside that muxes pins where o_pwm_own is low.
*/
// Local design decisions: the placing of the registers and the plain strobed port.

`include "ebp_defs.svh"
`default_nettype none
module ebp_bridge_pwm import ebp_pkg::*; #(
   parameter int DBW = 7
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_arst_n,
   // register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // pins, bit 0 is output a, bit 3 is output d
   output logic [3:0] o_pin_level,
   output logic [3:0] o_pwm_own,
   output logic [3:0] o_pin_oe
);
   logic [7:0] ctrl;
   logic [7:0] duty_high_byte;
   logic [9:0] duty_latched;
   logic [7:0] period_limit;
   logic [2:0] timer_control;
   logic [DBW-1:0] deadband_count;
   logic [3:0] pin_direction;
   logic [3:0] steer;
   logic period_flag;
   ebp_tb_t tb;
   ebp_gen_state_t state;
   ebp_bridge_mode_t mode;
   logic pwm_en;
   logic full_mode;
   logic base;
   logic dir_active;
   logic blank;
   logic dir_pending;
   logic lead_hit;
   logic [1:0] db_want;
   logic [1:0] db_out;
   logic [3:0] next_act;
   logic [3:0] act;
   logic [3:0] pol_vec;
   logic [9:0] duty_new;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return i_wr && (a == off);
   endfunction

   function automatic logic [3:0] own_mask(input logic [7:0] c, input logic [3:0] st);
      logic [3:0] m;
      m = 4'h0;
      if (c[`EBP_SEL_HI:`EBP_SEL_LO] == `EBP_PWM_SEL) begin
         unique case (ebp_bridge_mode_t'(c[`EBP_CFG_HI:`EBP_CFG_LO]))
            BM_SINGLE: m = st;
            BM_HALF: m = 4'h3;
            BM_FULL_FWD: m = 4'hF;
            BM_FULL_REV: m = 4'hF;
         endcase
      end
      return m;
   endfunction

   assign mode = ebp_bridge_mode_t'(ctrl[`EBP_CFG_HI:`EBP_CFG_LO]);
   assign pwm_en = (ctrl[`EBP_SEL_HI:`EBP_SEL_LO] == `EBP_PWM_SEL);
   assign full_mode = pwm_en && ctrl[`EBP_CFG_LO];
   assign duty_new = {duty_high_byte, ctrl[`EBP_DLO_HI:`EBP_DLO_LO]};
   assign pol_vec = {ctrl[`EBP_POL_BD], ctrl[`EBP_POL_AC],
                     ctrl[`EBP_POL_BD], ctrl[`EBP_POL_AC]};
   assign dir_pending = (dir_active != ctrl[`EBP_CFG_HI]);
   // lead hit marks the first of the last four timer counts of the period
   assign lead_hit = (tb.timer == period_limit - (`EBP_DIR_LEAD - 8'h01));

   // register writes
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ctrl <= `EBP_RST_CTRL;
         duty_high_byte <= `EBP_RST_DUTY_HI;
         period_limit <= `EBP_RST_PERIOD;
         timer_control <= `EBP_RST_TCTRL;
         deadband_count <= DBW'(`EBP_RST_DEADBAND);
         pin_direction <= `EBP_RST_PINDIR;
         steer <= `EBP_RST_STEER;
      end else begin
         if (hit(i_addr, `EBP_ADDR_CTRL)) begin
            ctrl <= i_wdata;
         end
         if (hit(i_addr, `EBP_ADDR_DUTY_HI)) begin
            duty_high_byte <= i_wdata;
         end
         if (hit(i_addr, `EBP_ADDR_PERIOD)) begin
            period_limit <= i_wdata;
         end
         if (hit(i_addr, `EBP_ADDR_TCTRL)) begin
            timer_control <= i_wdata[2:0];
         end
         if (hit(i_addr, `EBP_ADDR_DEADBAND)) begin
            deadband_count <= i_wdata[DBW-1:0];
         end
         if (hit(i_addr, `EBP_ADDR_PINDIR)) begin
            pin_direction <= i_wdata[3:0];
         end
         if (hit(i_addr, `EBP_ADDR_STEER)) begin
            steer <= i_wdata[3:0];
         end
      end
   end

   // period flag: the hardware set wins over a same-cycle write
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         period_flag <= 1'b0;
      end else if (tb.period_start) begin
         period_flag <= 1'b1;
      end else if (hit(i_addr, `EBP_ADDR_FLAG)) begin
         period_flag <= i_wdata[0];
      end
   end

   // read port, data valid only in the cycle after the strobe
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rdata <= 8'h00;
      end else if (!i_rd) begin
         o_rdata <= 8'h00;
      end else begin
         unique case (i_addr)
            `EBP_ADDR_CTRL: o_rdata <= ctrl;
            `EBP_ADDR_DUTY_HI: o_rdata <= duty_high_byte;
            `EBP_ADDR_DUTY_LAT: o_rdata <= duty_latched[9:2];
            `EBP_ADDR_PERIOD: o_rdata <= period_limit;
            `EBP_ADDR_TIMER: o_rdata <= tb.timer;
            `EBP_ADDR_TCTRL: o_rdata <= {5'h00, timer_control};
            `EBP_ADDR_DEADBAND: o_rdata <= 8'(deadband_count);
            `EBP_ADDR_PINDIR: o_rdata <= {4'h0, pin_direction};
            `EBP_ADDR_FLAG: o_rdata <= {7'h00, period_flag};
            `EBP_ADDR_STEER: o_rdata <= {4'h0, steer};
            default: o_rdata <= 8'h00;
         endcase
      end
   end

   // timer counts straight off i_clock, so pwm rate scales with it
   ebp_timebase u_timebase (
      .i_clock(i_clock),
      .i_arst_n(i_arst_n),
      .i_run(timer_control[`EBP_TRUN]),
      .i_prescale_sel(timer_control[`EBP_PS_HI:`EBP_PS_LO]),
      .i_period_limit(period_limit),
      .o_tb(tb)
   );

   // duty double buffer
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         duty_latched <= 10'h000;
      end else if (tb.period_start) begin
         duty_latched <= duty_new;
      end
   end

   // base waveform; a duty beyond the period never clears it
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         base <= 1'b0;
      end else if (tb.period_start) begin
         base <= (duty_new != 10'h000);
      end else if ({tb.timer, tb.sub} == duty_latched) begin
         base <= 1'b0;
      end
   end

   // start-up hold-off so the first pulse is never truncated
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state <= GS_IDLE;
      end else if (!pwm_en) begin
         state <= GS_IDLE;
      end else begin
         unique case (state)
            GS_IDLE: state <= GS_WAIT;
            GS_WAIT: if (tb.period_start) begin
               state <= GS_RUN;
            end
            GS_RUN: state <= GS_RUN;
            default: state <= GS_IDLE;
         endcase
      end
   end

   // full-bridge direction change
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         dir_active <= 1'b0;
         blank <= 1'b0;
      end else if (!full_mode) begin
         dir_active <= ctrl[`EBP_CFG_HI];
         blank <= 1'b0;
      end else if (dir_pending && lead_hit) begin
         dir_active <= ctrl[`EBP_CFG_HI];
         blank <= 1'b1;
      end else if (tb.period_start) begin
         blank <= 1'b0;
         // written too late for the lead window: switch at the boundary
         if (dir_pending) begin
            dir_active <= ctrl[`EBP_CFG_HI];
         end
      end
   end

   // half-bridge dead band, one delay per complementary output
   assign db_want[0] = (state == GS_RUN) && (mode == BM_HALF) && base;
   assign db_want[1] = (state == GS_RUN) && (mode == BM_HALF) && !base;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_db
         ebp_deadband #(.CW(DBW)) u_db (
            .i_clock(i_clock),
            .i_arst_n(i_arst_n),
            .i_want(db_want[g]),
            .i_tick(tb.inst_tick),
            .i_count(deadband_count),
            .o_active(db_out[g])
         );
      end
   endgenerate

   // output steering, d c b a
   always_comb begin
      next_act = 4'h0;
      if (state == GS_RUN) begin
         unique case (mode)
            BM_SINGLE: next_act = {4{base}} & steer;
            BM_HALF: next_act = {2'b00, db_out};
            BM_FULL_FWD, BM_FULL_REV: begin
               // dead band bypassed in both full modes
               if (!dir_active) begin
                  next_act = {base && !blank, 1'b0, 1'b0, 1'b1};
               end else begin
                  next_act = {1'b0, 1'b1, base && !blank, 1'b0};
               end
            end
         endcase
      end
   end

   // pin registers
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         act <= 4'h0;
         o_pin_level <= 4'h0;
         o_pwm_own <= 4'h0;
         o_pin_oe <= 4'h0;
      end else begin
         act <= next_act;
         o_pin_level <= next_act ^ pol_vec;
         o_pwm_own <= own_mask(ctrl, steer);
         o_pin_oe <= ~pin_direction;
      end
   end

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_arst_n);

   sequence dir_blank_s;
      full_mode && dir_pending && lead_hit;
   endsequence

   sequence mod_off_s;
      !act[1] && !act[3];
   endsequence

   release_all_a: assert property ((ctrl == 8'h00) |=> (o_pwm_own == 4'h0))
      else $error("pins still owned after control cleared");

   half_unused_a: assert property ((pwm_en && mode == BM_HALF) |=>
      (o_pwm_own == 4'h3))
      else $error("half bridge owns wrong pins");

   fwd_pins_a: assert property ((state == GS_RUN && full_mode && !dir_active
      && !blank) |=> (act[0] && !act[1] && !act[2] && act[3] == $past(base)))
      else $error("forward pin pattern wrong");

   rev_pins_a: assert property ((state == GS_RUN && full_mode && dir_active
      && !blank) |=> (!act[0] && act[1] == $past(base) && act[2] && !act[3]))
      else $error("reverse pin pattern wrong");

   // act is registered, so the blanked pattern shows one clock after blank
   dir_blank_a: assert property (dir_blank_s |=> blank ##1 mod_off_s)
      else $error("direction change did not blank modulated pins");

   blank_end_a: assert property (blank && tb.period_start |=> !blank)
      else $error("blanking outlived the period");

   duty_latch_a: assert property (tb.period_start |=>
      (duty_latched == $past(duty_new)))
      else $error("duty not latched at period start");

   duty_clear_a: assert property ((!tb.period_start && base &&
      {tb.timer, tb.sub} == duty_latched) |=> !base)
      else $error("base pwm not cleared at duty match");

   flag_set_a: assert property (tb.period_start |=> period_flag)
      else $error("period flag not set");

   hold_off_a: assert property ((state != GS_RUN) |=> (act == 4'h0))
      else $error("waveform before first period start");

   polarity_a: assert property (o_pin_level == (act ^ $past(pol_vec)))
      else $error("pin level ignores pair polarity");

   reset_dir_a: assert property ($rose(i_arst_n) |->
      (pin_direction == 4'hF && o_pin_oe == 4'h0))
      else $error("pins not inputs after reset");
endmodule
`default_nettype wire

// file: verification/ebp_switch_driver.sv
/*
 Bridge switch driver model: turns the block's pin drive into gate levels.
 Assumes pull-downs on every gate input and active-high switches.
*/
`default_nettype none
module ebp_switch_driver (
   // clock
   input wire logic i_clock,
   // pins from the block
   input wire logic [3:0] i_level,
   input wire logic [3:0] i_oe,
   input wire logic [3:0] i_own,
   // gate levels and fault count
   output logic [3:0] o_gate,
   output int o_shoot
);
   timeunit 1ns;
   timeprecision 1ps;
   // undriven or released pins fall to the pull-down, switch stays off
   assign o_gate = i_level & i_oe & i_own;
   initial o_shoot = 0;
   // upper a and lower b on together shorts the half bridge
   always @(negedge i_clock) begin
      if (o_gate[0] && o_gate[1]) o_shoot <= o_shoot + 1;
   end
endmodule
`default_nettype wire

// file: verification/enhanced_bridge_pwm_output_bench.sv
/*
 Self-checking bench for the enhanced bridge pwm block.
 Assumes rtl/ on the include path and a 25 MHz clock.
*/
`include "ebp_defs.svh"
`default_nettype none
module enhanced_bridge_pwm_output_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic [3:0] lvl;
   logic [3:0] own;
   logic [3:0] oe;
   logic [3:0] g;
   int shoot;
   int miscompares = 0;
   int checks = 0;

   ebp_bridge_pwm i_dut (.i_clock(clk), .i_arst_n(arst_n), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_pin_level(lvl), .o_pwm_own(own),
      .o_pin_oe(oe));
   ebp_switch_driver i_drv (.i_clock(clk), .i_level(lvl), .i_oe(oe), .i_own(own),
      .o_gate(g), .o_shoot(shoot));

   initial begin
      forever #20 clk = ~clk;
   end

   task automatic close_out();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic near(input string what, input int exp, input int tol, input int got);
      checks++;
      if (got < exp - tol || got > exp + tol) begin
         miscompares++;
         $display("Error %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd_reg(a, d);
      chk(what, exp, d);
   endtask

   // counts falling edges until the gate shows v; bounded
   task automatic wait_lvl(input int i, input logic v, output int n);
      n = 0;
      while (g[i] !== v) begin
         @(negedge clk);
         n++;
         if (n > 3000) begin
            miscompares++;
            $display("Error gate %0d expected %b seen timeout", i, v);
            close_out();
         end
      end
   endtask

   task automatic rise(input int i, output int n);
      int m;
      wait_lvl(i, 1'b0, m);
      wait_lvl(i, 1'b1, n);
      n += m;
   endtask

   // width and period of one pulse; returns at the following rise
   task automatic pulse(input int i, output int w, output int p);
      int l;
      rise(i, l);
      wait_lvl(i, 1'b0, w);
      rise(i, l);
      p = w + l;
   endtask

   task automatic hi_cnt(input int len, output int h[4]);
      h = '{0, 0, 0, 0};
      repeat (len) begin
         @(negedge clk);
         if ($isunknown(g)) begin
            checks++;
            miscompares++;
            $display("Error gate expected known seen %b", g);
         end
         for (int i = 0; i < 4; i++) h[i] += int'(g[i]);
      end
   endtask

   task automatic reset_regs();
      logic [7:0] ra[8] = '{`EBP_ADDR_CTRL, `EBP_ADDR_DUTY_HI, `EBP_ADDR_PERIOD,
         `EBP_ADDR_TCTRL, `EBP_ADDR_DEADBAND, `EBP_ADDR_PINDIR, `EBP_ADDR_STEER, `EBP_ADDR_FLAG};
      logic [7:0] rv[8] = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h0F, 8'h01, 8'h00};
      chk("oe at reset", 8'h00, {4'h0, oe});
      chk("own at reset", 8'h00, {4'h0, own});
      for (int k = 0; k < 8; k++) rd_chk("reset value", ra[k], rv[k]);
      wr_reg(`EBP_ADDR_DUTY_LAT, 8'hAA);
      rd_chk("latched ro", `EBP_ADDR_DUTY_LAT, 8'h00);
      wr_reg(8'h30, 8'h55);
      rd_chk("unmapped", 8'h30, 8'h00);
      $display("done reset_regs");
   endtask

   task automatic start_single();
      int w, p, f;
      int h[4];
      logic [7:0] d;
      logic [7:0] first;
      wr_reg(`EBP_ADDR_PERIOD, 8'h09);
      wr_reg(`EBP_ADDR_CTRL, 8'h0C);
      wr_reg(`EBP_ADDR_DUTY_HI, 8'h05);
      wr_reg(`EBP_ADDR_FLAG, 8'h00);
      wr_reg(`EBP_ADDR_TCTRL, 8'h04);
      rd_reg(`EBP_ADDR_FLAG, first);
      chk("flag early", 8'h00, first & 8'h01);
      d = first;
      f = 0;
      while (d[0] !== 1'b1 && f < 60) begin
         rd_reg(`EBP_ADDR_FLAG, d);
         f++;
      end
      chk("period flag", 8'h01, d & 8'h01);
      if (d[0] !== 1'b1) close_out();
      wr_reg(`EBP_ADDR_PINDIR, 8'h00);
      repeat (3) @(negedge clk);
      chk("oe on", 8'h0F, {4'h0, oe});
      chk("own single", 8'h01, {4'h0, own});
      pulse(0, w, p);
      near("width", 20, 1, w);
      near("period", 40, 0, p);
      wr_reg(`EBP_ADDR_STEER, 8'h0F);
      repeat (45) @(negedge clk);
      chk("own steer", 8'h0F, {4'h0, own});
      hi_cnt(40, h);
      near("steered d", 20, 1, h[3]);
      $display("done start_single");
   endtask

   task automatic duty_buffer();
      int w, p;
      int h[4];
      pulse(0, w, p);
      wr_reg(`EBP_ADDR_DUTY_HI, 8'h02);
      wait_lvl(0, 1'b0, w);
      near("held duty", 19, 1, w);
      pulse(0, w, p);
      near("new duty", 8, 1, w);
      rd_chk("latched", `EBP_ADDR_DUTY_LAT, 8'h02);
      wr_reg(`EBP_ADDR_DUTY_HI, 8'h00);
      repeat (45) @(negedge clk);
      hi_cnt(80, h);
      near("zero duty", 0, 0, h[0]);
      wr_reg(`EBP_ADDR_DUTY_HI, 8'h05);
      $display("done duty_buffer");
   endtask

   task automatic prescale();
      int w, p, m;
      for (int ps = 1; ps < 3; ps++) begin
         m = (ps == 1) ? 4 : 16;
         wr_reg(`EBP_ADDR_TCTRL, 8'h04 | 8'(ps));
         pulse(0, w, p);
         pulse(0, w, p);
         near("scaled period", 40 * m, 0, p);
         near("scaled width", 20 * m, m, w);
      end
      wr_reg(`EBP_ADDR_TCTRL, 8'h04);
      wr_reg(`EBP_ADDR_STEER, 8'h01);
      $display("done prescale");
   endtask

   task automatic release_restart();
      int w, p;
      wr_reg(`EBP_ADDR_CTRL, 8'h00);
      repeat (3) @(negedge clk);
      chk("own released", 8'h00, {4'h0, own});
      repeat (13) @(negedge clk);
      wr_reg(`EBP_ADDR_CTRL, 8'h0C);
      pulse(0, w, p);
      near("first width", 20, 1, w);
      near("first period", 40, 0, p);
      $display("done release_restart");
   endtask

   task automatic half_bridge();
      int w, p, s;
      int h[4];
      wr_reg(`EBP_ADDR_CTRL, 8'h8C);
      pulse(0, w, p);
      chk("half own", 8'h03, {4'h0, own});
      hi_cnt(40, h);
      near("half a", 20, 4, h[0]);
      near("half b", 20, 4, h[1]);
      near("half c", 0, 0, h[2] + h[3]);
      wr_reg(`EBP_ADDR_DEADBAND, 8'h02);
      repeat (40) @(negedge clk);
      s = shoot;
      hi_cnt(40, h);
      near("band a", 12, 4, h[0]);
      near("band b", 12, 4, h[1]);
      near("overlap", s, 0, shoot);
      // drivers off around a polarity change to spare the switches
      wr_reg(`EBP_ADDR_PINDIR, 8'h0F);
      wr_reg(`EBP_ADDR_CTRL, 8'h8F);
      wr_reg(`EBP_ADDR_PINDIR, 8'h00);
      repeat (40) @(negedge clk);
      hi_cnt(40, h);
      near("low a", 28, 4, h[0]);
      near("low b", 28, 4, h[1]);
      wr_reg(`EBP_ADDR_PINDIR, 8'h0F);
      wr_reg(`EBP_ADDR_CTRL, 8'h8C);
      wr_reg(`EBP_ADDR_PINDIR, 8'h00);
      wr_reg(`EBP_ADDR_DEADBAND, 8'h7F);
      repeat (80) @(negedge clk);
      hi_cnt(80, h);
      near("long band", 0, 0, h[0] + h[1]);
      $display("done half_bridge");
   endtask

   task automatic full_bridge();
      int n;
      int h[4];
      wr_reg(`EBP_ADDR_DEADBAND, 8'h05);
      wr_reg(`EBP_ADDR_DUTY_HI, 8'h09);
      wr_reg(`EBP_ADDR_CTRL, 8'h4C);
      repeat (80) @(negedge clk);
      hi_cnt(40, h);
      near("fwd a", 40, 0, h[0]);
      near("fwd bc", 0, 0, h[1] + h[2]);
      near("fwd d", 36, 1, h[3]);
      rise(3, n);
      wr_reg(`EBP_ADDR_CTRL, 8'hCC);
      rise(2, n);
      near("swap time", 23, 3, n);
      chk("blank d", 8'h00, {7'h00, g[3]});
      chk("swap a", 8'h00, {7'h00, g[0]});
      rise(1, n);
      near("lead", 16, 1, n);
      hi_cnt(40, h);
      near("rev c", 40, 0, h[2]);
      near("rev ad", 0, 0, h[0] + h[3]);
      near("rev b", 36, 1, h[1]);
      $display("done full_bridge");
   endtask

   initial begin
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      reset_regs();
      start_single();
      duty_buffer();
      prescale();
      release_restart();
      half_bridge();
      full_bridge();
      close_out();
   end
endmodule
`default_nettype wire
